/* File: itc_pkg.sv */
// Purpose: shared constants and types for the iteration stop config block
// Assumes: one 32-bit config register and one status register reached over AXI4-Lite
// Notes: offsets, field positions and limits are named here only
package itc_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] ITC_ADDR_W = 4'h4;
  localparam logic [3:0] ITC_CFG_OFFS = 4'h0;
  localparam logic [3:0] ITC_STAT_OFFS = 4'h4;
  localparam logic [31:0] ITC_CFG_RESET = 32'h0000_0000;
  // keeps writable bits 31:24, 20:16, 14:8, 5:0
  localparam logic [31:0] ITC_CFG_WMASK = 32'hff1f_7f3f;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int ITC_SNR_LSB = 24;
  localparam int ITC_CEIL_LSB = 16;
  localparam int ITC_SB_LSB = 8;
  localparam int ITC_PRO_LSB = 0;

  // ----------------------------------------------------------------------
  // limits
  // ----------------------------------------------------------------------
  localparam logic [7:0] ITC_SNR_MAX = 8'h64;
  localparam logic [5:0] ITC_CEIL_ZERO_MEANS = 6'h20;
  localparam logic [6:0] ITC_SB_MAX = 7'h51;
  localparam logic [5:0] ITC_PRO_MIN = 6'h04;
  localparam logic [5:0] ITC_PRO_MAX = 6'h30;
  localparam logic [2:0] ITC_PRO_ALIGN_MASK = 3'h7;

  // axi responses
  localparam logic [1:0] ITC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ITC_RESP_SLVERR = 2'h2;

  // fields of the configuration word
  typedef struct packed {
    logic [7:0] snr_threshold;
    logic [2:0] rsv_hi;
    logic [4:0] iteration_ceiling;
    logic rsv_mid;
    logic [6:0] sub_block_count;
    logic [1:0] rsv_lo;
    logic [5:0] prolog_length;
  } itc_cfg_s;

  // values handed to the decoder core
  typedef struct packed {
    logic snr_test_enable;
    logic [7:0] snr_threshold;
    logic [5:0] iteration_limit;
    logic [6:0] sub_block_count;
    logic [5:0] prolog_length;
  } itc_core_s;

endpackage : itc_pkg

/* File: itc_decode.sv */
// Purpose: turns the stored word into decoder-facing values and checks
// Assumes: pure combinational, same clock domain as its user
// Notes: flags out-of-range settings without altering them
`timescale 1ns/1ps
module itc_decode (
  input wire logic [31:0] cfg_word,
  input wire logic shared_mode,
  output itc_pkg::itc_core_s core,
  output logic [3:0] range_err
);

  itc_pkg::itc_cfg_s f;

  // ----------------------------------------------------------------------
  // field decode and range checks
  // ----------------------------------------------------------------------
  always_comb
  begin
    f = itc_pkg::itc_cfg_s'(cfg_word);
    core.snr_threshold = f.snr_threshold;
    core.snr_test_enable = (f.snr_threshold != 8'h00);
    // zero encodes the top count
    if (f.iteration_ceiling == 5'h00)
      core.iteration_limit = itc_pkg::ITC_CEIL_ZERO_MEANS;
    else
      core.iteration_limit = {1'b0, f.iteration_ceiling};
    // sub-block count only matters in shared mode
    core.sub_block_count = shared_mode ? f.sub_block_count : 7'h00;
    core.prolog_length = f.prolog_length;
    range_err[0] = (f.snr_threshold > itc_pkg::ITC_SNR_MAX);
    range_err[1] = (f.sub_block_count > itc_pkg::ITC_SB_MAX);
    range_err[2] = (f.prolog_length < itc_pkg::ITC_PRO_MIN) ||
                   (f.prolog_length > itc_pkg::ITC_PRO_MAX);
    range_err[3] = shared_mode &&
      ((f.prolog_length[2:0] & itc_pkg::ITC_PRO_ALIGN_MASK) != 3'h0);
  end

endmodule : itc_decode

/* File: itc_stop_ctl.sv */
// Purpose: per-iteration stop decision of the decoder core
// Assumes: core pulses iter_done once per finished iteration
// Notes: snr compare is strictly greater than
`timescale 1ns/1ps
module itc_stop_ctl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic iter_done,
  input wire logic [7:0] snr_meas,
  input itc_pkg::itc_core_s core,
  output logic busy,
  output logic stop,
  output logic by_snr,
  output logic [5:0] iters
);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN} itc_state_e;
  itc_state_e state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic stop_q, stop_d;
  logic snr_q, snr_d;
  logic snr_hit;
  logic cap_hit;

  // ----------------------------------------------------------------------
  // stop evaluation
  // ----------------------------------------------------------------------
  always_comb
  begin
    snr_hit = core.snr_test_enable && (snr_meas > core.snr_threshold);
    cap_hit = ((cnt_q + 6'h01) >= core.iteration_limit);
    state_d = state_q;
    cnt_d = cnt_q;
    stop_d = 1'b0;
    snr_d = snr_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (start)
        begin
          state_d = ST_RUN;
          cnt_d = 6'h00;
          snr_d = 1'b0;
        end
      end
      ST_RUN:
      begin
        if (iter_done)
        begin
          cnt_d = cnt_q + 6'h01;
          if (snr_hit || cap_hit)
          begin
            stop_d = 1'b1;
            snr_d = snr_hit;
            state_d = ST_IDLE;
          end
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 6'h00;
      stop_q <= 1'b0;
      snr_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      stop_q <= stop_d;
      snr_q <= snr_d;
    end
  end

  assign busy = (state_q == ST_RUN);
  assign stop = stop_q;
  assign by_snr = snr_q;
  assign iters = cnt_q;

endmodule : itc_stop_ctl

/* File: itc_top.sv */
// Purpose: iteration stop configuration register with AXI4-Lite access
// Assumes: single clock aclk, synchronous active-low reset aresetn
// Notes: one config word, one status word; other addresses SLVERR
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

// Notes on behaviour
// - top byte snr threshold stops decoding
// - zero threshold disables snr test; max 100
// - 5-bit iteration ceiling, zero means 32
// - 7-bit sub-block count, shared mode only
// - prolog length 4 to 48 in low bits
// - reserved bits read zero, ignore writes
module itc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic shared_mode,
  input wire logic dec_start,
  input wire logic dec_iter_done,
  input wire logic [7:0] dec_snr_meas,
  output logic dec_stop,
  output logic dec_stop_by_snr,
  output itc_pkg::itc_core_s dec_cfg
);

  // ----------------------------------------------------------------------
  // storage and write channel state
  // ----------------------------------------------------------------------
  logic [31:0] cfg_q, cfg_d;
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [3:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  itc_pkg::itc_core_s core_cfg;
  itc_pkg::itc_core_s dec_cfg_q;
  logic [3:0] range_err;
  logic run_busy;
  logic run_stop;
  logic run_by_snr;
  logic [5:0] run_iters;
  logic [31:0] status_word;
  logic [31:0] merged;

  // ----------------------------------------------------------------------
  // field decode and checks
  // ----------------------------------------------------------------------
  itc_decode u_decode (
    .cfg_word(cfg_q),
    .shared_mode(shared_mode),
    .core(core_cfg),
    .range_err(range_err)
  );

  // ----------------------------------------------------------------------
  // iteration run control
  // ----------------------------------------------------------------------
  itc_stop_ctl u_stop (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(dec_start),
    .iter_done(dec_iter_done),
    .snr_meas(dec_snr_meas),
    .core(dec_cfg_q),
    .busy(run_busy),
    .stop(run_stop),
    .by_snr(run_by_snr),
    .iters(run_iters)
  );

  // status: range errors, busy, last stop cause, iteration count
  assign status_word = {16'h0000, 2'h0, run_iters, 2'h0, run_by_snr,
                        run_busy, range_err};

  // ----------------------------------------------------------------------
  // write path: address and data taken in either order
  // ----------------------------------------------------------------------
  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    cfg_d = cfg_q;
    merged = cfg_q;
    if (s_axi_awvalid && !aw_have_q)
    begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_q)
    begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    // commit once both halves are held and no response is pending
    if (aw_have_q && w_have_q && !bvalid_q)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      for (int i = 0; i < 4; i++)
        if (wstrb_q[i])
          merged[i*8 +: 8] = wdata_q[i*8 +: 8];
      if (awaddr_q[3:2] == itc_pkg::ITC_CFG_OFFS[3:2])
      begin
        cfg_d = merged & itc_pkg::ITC_CFG_WMASK;
        bresp_d = itc_pkg::ITC_RESP_OKAY;
      end
      else if (awaddr_q[3:2] == itc_pkg::ITC_STAT_OFFS[3:2])
        bresp_d = itc_pkg::ITC_RESP_OKAY; // status is read-only
      else
        bresp_d = itc_pkg::ITC_RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------------
  // read path: one read outstanding
  // ----------------------------------------------------------------------
  always_comb
  begin
    arready_d = 1'b0;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    if (s_axi_arvalid && !arready_q && !rvalid_q)
    begin
      arready_d = 1'b1;
      rvalid_d = 1'b1;
      rresp_d = itc_pkg::ITC_RESP_OKAY;
      if (s_axi_araddr[3:2] == itc_pkg::ITC_CFG_OFFS[3:2])
        rdata_d = cfg_q & itc_pkg::ITC_CFG_WMASK;
      else if (s_axi_araddr[3:2] == itc_pkg::ITC_STAT_OFFS[3:2])
        rdata_d = status_word;
      else
      begin
        rdata_d = 32'h0000_0000;
        rresp_d = itc_pkg::ITC_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_q <= itc_pkg::ITC_CFG_RESET;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      dec_cfg_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      // registered so the core sees a settled copy
      dec_cfg_q <= core_cfg;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign dec_stop = run_stop;
  assign dec_stop_by_snr = run_by_snr;
  assign dec_cfg = dec_cfg_q;

endmodule : itc_top

/* File: itc_asserts.sv */
// Purpose: port-level checks on the iteration stop config block
// Assumes: one clock aclk, sync active-low aresetn
// Notes: bound into itc_top at the foot of this file
`timescale 1ns/1ps
module itc_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic shared_mode,
  input wire logic [7:0] dec_snr_meas,
  input wire logic dec_stop,
  input wire logic dec_stop_by_snr,
  input wire itc_pkg::itc_core_s dec_cfg
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  // all checks share one domain, so one clock and disable
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_rsv_read_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[23:21] == 3'h0 && !s_axi_rdata[15] && s_axi_rdata[7:6] == 2'h0)
    else $error("reserved bits read back nonzero");
  a_reset_clear: assert property ($rose(aresetn) |->
    dec_cfg == '0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("state not cleared by reset");
  a_ceil_range: assert property ($past(aresetn) |->
    dec_cfg.iteration_limit != 6'h00 && dec_cfg.iteration_limit <= 6'h20)
    else $error("iteration limit outside 1 to 32");
  a_snr_enable: assert property (
    dec_cfg.snr_test_enable == (dec_cfg.snr_threshold != 8'h00))
    else $error("snr enable disagrees with threshold");
  // sub-block count only reaches the core in shared mode
  a_sb_shared: assert property ($past(aresetn) && !$past(shared_mode) |->
    dec_cfg.sub_block_count == 7'h00)
    else $error("sub-block count leaks outside shared mode");
  a_stop_pulse: assert property (dec_stop |=> !dec_stop)
    else $error("stop held longer than one cycle");
  a_snr_cause: assert property (dec_stop && dec_stop_by_snr |->
    $past(dec_cfg.snr_test_enable) &&
    $past(dec_snr_meas) > $past(dec_cfg.snr_threshold))
    else $error("snr stop without snr above threshold");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |->
    ##[1:2] s_axi_rvalid)
    else $error("read response late");
endmodule : itc_asserts

bind itc_top itc_asserts u_itc_asserts (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid, .shared_mode,
  .dec_snr_meas, .dec_stop, .dec_stop_by_snr, .dec_cfg);

/* File: itc_tb.sv */
// Purpose: self-checking bench for the iteration stop config block
// Assumes: bus ready inputs held high, so answers are taken at once
// Notes: table of register writes first, then decoder stop runs
`timescale 1ns/1ps
`define ITC_CHK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic shared_mode = 1'b0, dec_start = 1'b0, dec_iter_done = 1'b0;
  logic [7:0] dec_snr_meas = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, dec_stop, dec_stop_by_snr;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic st;
  itc_pkg::itc_core_s dec_cfg;
  int miscompares = 0;
  int n_tests = 0;

  // ----------------------------------------
  // table: written word, mode, expected limit and sub-blocks
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] wd;
    logic sh;
    logic [5:0] lim;
    logic [6:0] sb;
  } itc_row_s;
  localparam int NROWS = 5;
  itc_row_s rows [NROWS] = '{
    '{32'hffff_ffff, 1'b1, 6'h1f, 7'h7f},
    '{32'h00e0_80c0, 1'b0, 6'h20, 7'h00},
    '{32'h6400_5130, 1'b0, 6'h20, 7'h00},
    '{32'h0101_0004, 1'b1, 6'h01, 7'h00},
    '{32'h0010_2818, 1'b1, 6'h10, 7'h28}};

  // clock at 50 MHz
  always #10 aclk = ~aclk;

  itc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .shared_mode,
    .dec_start, .dec_iter_done, .dec_snr_meas, .dec_stop,
    .dec_stop_by_snr, .dec_cfg);

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic hang();
    miscompares++;
    $display("wrong value bus answer expected 1 seen 0");
    print_verdict();
  endtask : hang

  // ----------------------------------------
  // bus tasks: called just after a rising edge
  // ----------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    if (i == 40)
      hang();
    r = s_axi_bresp;
  endtask : axi_wr

  // extra edge at the end so a following read never re-raises arvalid
  // in the same step that lowered it
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    if (i == 40)
      hang();
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask : axi_rd

  task automatic dec_run();
    dec_start <= 1'b1;
    @(posedge aclk);
    dec_start <= 1'b0;
    @(posedge aclk);
  endtask : dec_run

  // one iteration; watch a few cycles so a late stop is still caught
  task automatic iter(input logic [7:0] s, output logic stp);
    dec_iter_done <= 1'b1;
    dec_snr_meas <= s;
    @(posedge aclk);
    dec_iter_done <= 1'b0;
    stp = 1'b0;
    repeat (3)
    begin
      @(posedge aclk);
      stp |= dec_stop;
    end
  endtask : iter

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(4'h0, rd, rs);
    `ITC_CHK("cfg reset", 32'h0000_0000, rd)
    `ITC_CHK("limit reset", 6'h20, dec_cfg.iteration_limit)
    // only the last shared-mode row keeps the prolog a multiple of eight
    for (int k = 0; k < NROWS; k++)
    begin
      shared_mode <= rows[k].sh;
      axi_wr(4'h0, rows[k].wd, rs);
      `ITC_CHK("write resp", 2'h0, rs)
      axi_rd(4'h0, rd, rs);
      `ITC_CHK("readback", rows[k].wd & 32'hff1f_7f3f, rd)
      `ITC_CHK("threshold", rows[k].wd[31:24], dec_cfg.snr_threshold)
      `ITC_CHK("snr on", |rows[k].wd[31:24], dec_cfg.snr_test_enable)
      `ITC_CHK("limit", rows[k].lim, dec_cfg.iteration_limit)
      `ITC_CHK("sub blocks", rows[k].sb, dec_cfg.sub_block_count)
      `ITC_CHK("prolog", rows[k].wd[5:0], dec_cfg.prolog_length)
    end
    // unmapped place: refused, config left alone
    axi_wr(4'h8, 32'hffff_ffff, rs);
    `ITC_CHK("unmapped wr", 2'h2, rs)
    axi_rd(4'h8, rd, rs);
    `ITC_CHK("unmapped rd", 2'h2, rs)
    axi_rd(4'h0, rd, rs);
    `ITC_CHK("cfg kept", 32'h0010_2818, rd)
    // every checked field out of range in shared mode: all four flags up
    axi_wr(4'h0, 32'hffff_ffff, rs);
    axi_rd(4'h4, rd, rs);
    `ITC_CHK("range flags", 32'h0000_000f, rd)
    // threshold 50, ceiling 4: equal snr must not stop
    shared_mode <= 1'b0;
    axi_wr(4'h0, 32'h3204_0008, rs);
    dec_run();
    iter(8'h32, st);
    `ITC_CHK("equal snr", 1'b0, st)
    iter(8'h33, st);
    `ITC_CHK("snr stop", 1'b1, st)
    `ITC_CHK("by snr", 1'b1, dec_stop_by_snr)
    // two iterations done, stop by snr, no range flag
    axi_rd(4'h4, rd, rs);
    `ITC_CHK("snr status", 32'h0000_0220, rd)
    // threshold 0 disables snr test; ceiling 0 runs 32 iterations
    axi_wr(4'h0, 32'h0000_0008, rs);
    dec_run();
    for (int j = 1; j <= 32; j++)
    begin
      iter(8'hff, st);
      `ITC_CHK("ceiling stop", j == 32, st)
    end
    `ITC_CHK("not by snr", 1'b0, dec_stop_by_snr)
    axi_rd(4'h4, rd, rs);
    `ITC_CHK("iterations done", 32'h0000_2000, rd)
    // second reset after the run has stopped: word cleared, zero prolog flagged
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(4'h0, rd, rs);
    `ITC_CHK("cfg re-reset", 32'h0000_0000, rd)
    `ITC_CHK("prolog re-reset", 6'h00, dec_cfg.prolog_length)
    axi_rd(4'h4, rd, rs);
    `ITC_CHK("status re-reset", 32'h0000_0004, rd)
    print_verdict();
  end
endmodule : testbench
